/* File: spi_map.vh */
// Register offsets, field positions, reset values and rate codes of the SPI block.
// Assumes an 8-bit register port with a 2-bit address and one 250 MHz core clock.
//
// Contract
// - Master seeing select low raises mode fault
// - Mode fault clears enable and master select
// - Mode fault clears: status read, control write
// - Enable and master ignored while fault stands
// - Byte done with done flag set: overrun
// - Overrun keeps first byte, later bytes dropped
// - Status read clears overrun flag
// - Data write while busy discarded, collision set
// - Collision flag never raises an interrupt
// - Data write never clears collision flag
// - Received byte held in synchronous buffer
// - Wait mode runs normally, interrupts end wait
// - Halt freezes registers, SPI inactive until woken (a slave selected at halt entry keeps shifting and sets the done flag)
// - Slave end of transfer wakes from halt
// - Halt wake only if select low at entry
// - One shared request, gated by enable, mask
// - Control layout: irq, enable, div, master, pol, pha, rate
// - Slave without new write echoes last byte
// - Done flag set per byte, status then data clears
// - Rate codes pick core clock over 4..128
`ifndef SPI_MAP_VH
`define SPI_MAP_VH

`define ADDR_CTRL 2'h0
`define ADDR_STAT 2'h1
`define ADDR_DATA 2'h2
`define RD_NONE 8'h00

`define CR_IRQ_EN 7
`define CR_PERIPH_EN 6
`define CR_DIV_SEL 5
`define CR_MASTER 4
`define CR_CPOL 3
`define CR_CPHA 2
`define CR_RATE_HI 1
`define CR_RATE_LO 0
`define CR_RESET 8'h00

`define SR_OUT_DIS 2
`define SR_SSM 1
`define SR_SSI 0
`define SR_RESET 3'h0

`define RATE_DIV4 3'h4
`define RATE_DIV8 3'h0
`define RATE_DIV16 3'h1
`define RATE_DIV32 3'h6
`define RATE_DIV64 3'h2
`define RATE_DIV128 3'h3
`define HALF_DIV4 7'h01
`define HALF_DIV8 7'h03
`define HALF_DIV16 7'h07
`define HALF_DIV32 7'h0f
`define HALF_DIV64 7'h1f
`define HALF_DIV128 7'h3f

`define EDGE_LAST 4'hf

`endif

/* File: spi_rate_div.v */
// Serial clock divider: one-cycle pulse every half period of the master clock.
// Assumes run drops whenever no master transfer is in progress.
`include "spi_map.vh"
`default_nettype none

module spi_rate_div (
  input wire core_clk,   // Core clock
  input wire sys_rst,    // Synchronous reset, active high
  input wire run,        // Count while high
  input wire [2:0] rate, // Divider select over rate field
  output reg tick        // Half-period pulse
);

  reg [6:0] cnt;
  reg [6:0] last;

  // ----------------------------------------
  // Rate decode
  // ----------------------------------------
  // rate code decode
  always @* begin
    case (rate)
      `RATE_DIV4: last = `HALF_DIV4;
      `RATE_DIV8: last = `HALF_DIV8;
      `RATE_DIV16: last = `HALF_DIV16;
      `RATE_DIV32: last = `HALF_DIV32;
      `RATE_DIV64: last = `HALF_DIV64;
      default: last = `HALF_DIV128;
    endcase
  end

  always @(posedge core_clk) begin
    if (sys_rst || !run) begin
      cnt <= 7'h00;
      tick <= 1'b0;
    end else if (cnt == last) begin
      cnt <= 7'h00;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 7'h01;
      tick <= 1'b0;
    end
  end

endmodule // spi_rate_div
`default_nettype wire

/* File: spi_rx_hold.v */
// Receive buffer: the byte software reads from the data register.
// Assumes load is a one-cycle pulse from the shift engine.
`default_nettype none

module spi_rx_hold (
  input wire core_clk,   // Core clock
  input wire sys_rst,    // Synchronous reset, active high
  input wire load,       // Take a new byte
  input wire [7:0] din,  // Byte from the shift register
  output reg [7:0] q     // Held byte
);

  always @(posedge core_clk) begin
    if (sys_rst) begin
      q <= 8'h00;
    end else if (load) begin
      q <= din;
    end
  end

endmodule // spi_rx_hold
`default_nettype wire

/* File: spi_error_power_irq.v */
// SPI core: control and status registers, error flags, byte shifter,
// shared interrupt request and wait/halt behaviour.
// Assumes register port and pin inputs synchronous to core_clk.
`include "spi_map.vh"
`default_nettype none

module spi_error_power_irq (
  input wire core_clk,        // Core clock, 250 MHz
  input wire sys_rst,         // Synchronous reset, active high
  input wire [1:0] reg_addr,  // Register address
  input wire [7:0] reg_wdata, // Write data
  input wire reg_wr,          // Write strobe
  input wire reg_rd,          // Read strobe
  output reg [7:0] reg_rdata, // Read data, cycle after strobe
  input wire cpu_irq_mask,    // Processor interrupt mask
  input wire wait_mode,       // Processor in wait
  input wire halt_mode,       // Processor in halt
  input wire ss_n_in,         // Slave select pin, active low
  input wire sck_in,          // Serial clock pin level
  output reg sck_out,         // Serial clock drive
  output reg sck_oe,          // Serial clock enable
  input wire mosi_in,         // Master-out pin level
  output reg mosi_out,        // Master-out drive
  output reg mosi_oe,         // Master-out enable
  input wire miso_in,         // Master-in pin level
  output reg miso_out,        // Master-in drive
  output reg miso_oe,         // Master-in enable
  output reg spi_irq,         // Shared interrupt request
  output reg wait_exit,       // Ends processor wait
  output reg halt_wake        // Ends processor halt, pulse
);

  localparam ST_IDLE = 1'b0;
  localparam ST_SHIFT = 1'b1;

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg irq_en;
  reg periph_en;
  reg div_sel;
  reg master_sel;
  reg cpol;
  reg cpha;
  reg [1:0] rate_field;
  reg out_dis;
  reg soft_select_mgmt;
  reg soft_select_level;
  reg done_flag;
  reg write_collision_flag_flag;
  reg ovr_flag;
  reg mode_fault_flag_flag;
  reg done_armed;
  reg write_collision_flag_armed;
  reg mode_fault_flag_armed;
  reg xfer_state;
  reg [3:0] edge_cnt;
  reg [7:0] shreg;
  reg dout;
  reg sck_lvl;
  reg sck_prev;
  reg halt_q;
  reg halt_armed;

  wire m_tick;
  wire [7:0] rx_q;

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  // registers frozen in halt
  wire acc_ok = !halt_mode;
  wire wr_cr = reg_wr && acc_ok && (reg_addr == `ADDR_CTRL);
  wire wr_sr = reg_wr && acc_ok && (reg_addr == `ADDR_STAT);
  wire wr_dr = reg_wr && acc_ok && (reg_addr == `ADDR_DATA);
  wire rd_sr = reg_rd && acc_ok && (reg_addr == `ADDR_STAT);
  wire rd_dr = reg_rd && acc_ok && (reg_addr == `ADDR_DATA);

  // ----------------------------------------
  // Select and transfer events
  // ----------------------------------------
  wire ss_int = soft_select_mgmt ? soft_select_level : ss_n_in;
  wire mode_fault_ev = master_sel && !ss_int && !halt_mode;
  wire slave_sel = periph_en && !master_sel && !ss_int;
  wire slave_live = slave_sel && (!halt_mode || halt_armed);
  wire m_run = (xfer_state == ST_SHIFT) && master_sel && periph_en && !halt_mode;

  wire edge_ev = master_sel ? m_tick : (slave_live && (sck_in != sck_prev));
  wire edge_lead = master_sel ? (sck_lvl == cpol) : (sck_in != cpol);
  wire sample_ev = edge_ev && (edge_lead ^ cpha);
  wire drive_ev = edge_ev && !(edge_lead ^ cpha);
  wire din = master_sel ? miso_in : mosi_in;
  wire byte_done = edge_ev && (xfer_state == ST_SHIFT) && (edge_cnt == `EDGE_LAST);
  wire [7:0] rx_byte = sample_ev ? {shreg[6:0], din} : shreg;

  // Slave with CPHA low is busy for the whole select window
  wire busy = (xfer_state == ST_SHIFT) || (slave_sel && !cpha);
  wire write_collision_flag_ev = wr_dr && busy;
  // Writes locked while done flag stands unacknowledged
  wire dr_write_ok = wr_dr && !busy && (!done_flag || done_armed);
  wire allow_set = !mode_fault_flag_flag || mode_fault_flag_armed;
  wire any_event = done_flag || ovr_flag || mode_fault_flag_flag;

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  spi_rate_div u_rate (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .run(m_run),
    .rate({div_sel, rate_field}),
    .tick(m_tick)
  );

  // buffer loads only with done flag clear
  spi_rx_hold u_rx (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .load(byte_done && !done_flag),
    .din(rx_byte),
    .q(rx_q)
  );

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (sys_rst) begin
      irq_en <= 1'b0;
      periph_en <= 1'b0;
      div_sel <= 1'b0;
      master_sel <= 1'b0;
      cpol <= 1'b0;
      cpha <= 1'b0;
      rate_field <= 2'h0;
    end else begin
      if (wr_cr) begin
        irq_en <= reg_wdata[`CR_IRQ_EN];
        div_sel <= reg_wdata[`CR_DIV_SEL];
        cpol <= reg_wdata[`CR_CPOL];
        cpha <= reg_wdata[`CR_CPHA];
        rate_field <= reg_wdata[`CR_RATE_HI:`CR_RATE_LO];
        periph_en <= reg_wdata[`CR_PERIPH_EN] && allow_set;
        master_sel <= reg_wdata[`CR_MASTER] && allow_set;
      end
      if (mode_fault_ev) begin
        periph_en <= 1'b0;
        master_sel <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Status register and flags
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (sys_rst) begin
      {out_dis, soft_select_mgmt, soft_select_level} <= `SR_RESET;
      done_flag <= 1'b0;
      write_collision_flag_flag <= 1'b0;
      ovr_flag <= 1'b0;
      mode_fault_flag_flag <= 1'b0;
      done_armed <= 1'b0;
      write_collision_flag_armed <= 1'b0;
      mode_fault_flag_armed <= 1'b0;
    end else begin
      if (wr_sr) begin
        out_dis <= reg_wdata[`SR_OUT_DIS];
        soft_select_mgmt <= reg_wdata[`SR_SSM];
        soft_select_level <= reg_wdata[`SR_SSI];
      end

      if (byte_done) begin
        done_flag <= 1'b1;
        done_armed <= 1'b0;
      end else if (done_armed && (rd_dr || wr_dr)) begin
        done_flag <= 1'b0;
        done_armed <= 1'b0;
      end else if ((rd_sr || wr_sr) && done_flag) begin
        done_armed <= 1'b1;
      end

      if (byte_done && done_flag) begin
        ovr_flag <= 1'b1;
      end else if (rd_sr) begin
        ovr_flag <= 1'b0;
      end

      if (write_collision_flag_ev) begin
        write_collision_flag_flag <= 1'b1;
      end else if (write_collision_flag_armed && rd_dr) begin
        write_collision_flag_flag <= 1'b0;
        write_collision_flag_armed <= 1'b0;
      end else if (rd_sr && write_collision_flag_flag) begin
        write_collision_flag_armed <= 1'b1;
      end

      if (mode_fault_ev) begin
        mode_fault_flag_flag <= 1'b1;
        mode_fault_flag_armed <= 1'b0;
      end else if (mode_fault_flag_armed && wr_cr) begin
        mode_fault_flag_flag <= 1'b0;
        mode_fault_flag_armed <= 1'b0;
      end else if (rd_sr && mode_fault_flag_flag) begin
        mode_fault_flag_armed <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Shift engine
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (sys_rst) begin
      xfer_state <= ST_IDLE;
      edge_cnt <= 4'h0;
      shreg <= 8'h00;
      dout <= 1'b0;
      sck_lvl <= 1'b0;
      sck_prev <= 1'b0;
    end else begin
      sck_prev <= sck_in;
      if (!periph_en || (!master_sel && !slave_sel)) begin
        // Select lost mid-byte: drop the partial byte count
        xfer_state <= ST_IDLE;
        edge_cnt <= 4'h0;
        sck_lvl <= cpol;
        dout <= shreg[7];
        if (dr_write_ok) begin
          shreg <= reg_wdata;
          dout <= reg_wdata[7];
        end
      end else if (dr_write_ok) begin
        shreg <= reg_wdata;
        if (!cpha) begin
          dout <= reg_wdata[7];
        end
        if (master_sel) begin
          xfer_state <= ST_SHIFT;
          edge_cnt <= 4'h0;
          sck_lvl <= cpol;
        end
      end else if (edge_ev) begin
        // received bits shift in, echoed next
        if (sample_ev) begin
          shreg <= {shreg[6:0], din};
        end
        if (drive_ev) begin
          dout <= shreg[7];
        end
        if (master_sel) begin
          sck_lvl <= !sck_lvl;
        end
        edge_cnt <= edge_cnt + 4'h1;
        xfer_state <= byte_done ? ST_IDLE : ST_SHIFT;
      end else begin
        case (xfer_state)
          ST_IDLE: begin
            sck_lvl <= cpol;
          end
          ST_SHIFT: begin
            xfer_state <= ST_SHIFT;
          end
          default: begin
            xfer_state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Halt entry capture
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (sys_rst) begin
      halt_q <= 1'b0;
      halt_armed <= 1'b0;
    end else begin
      halt_q <= halt_mode;
      if (halt_mode && !halt_q) begin
        halt_armed <= !ss_int;
      end else if (!halt_mode) begin
        halt_armed <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Requests and wake-up
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (sys_rst) begin
      spi_irq <= 1'b0;
      wait_exit <= 1'b0;
      halt_wake <= 1'b0;
    end else begin
      spi_irq <= irq_en && !cpu_irq_mask && any_event;
      wait_exit <= wait_mode && irq_en && !cpu_irq_mask && any_event;
      halt_wake <= halt_mode && halt_armed && !master_sel && byte_done && irq_en && !cpu_irq_mask;
    end
  end

  // ----------------------------------------
  // Pins
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (sys_rst) begin
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe <= 1'b0;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      sck_out <= sck_lvl;
      sck_oe <= periph_en && master_sel;
      mosi_out <= dout;
      mosi_oe <= periph_en && master_sel && !out_dis;
      miso_out <= dout;
      miso_oe <= slave_sel && !out_dis;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= `RD_NONE;
    end else if (reg_rd && acc_ok) begin
      case (reg_addr)
        `ADDR_CTRL: begin
          reg_rdata <= {irq_en, periph_en, div_sel, master_sel, cpol, cpha, rate_field};
        end
        `ADDR_STAT: begin
          reg_rdata <= {done_flag, write_collision_flag_flag, ovr_flag, mode_fault_flag_flag, 1'b0,
                        out_dis, soft_select_mgmt, soft_select_level};
        end
        `ADDR_DATA: begin
          reg_rdata <= rx_q;
        end
        default: begin
          reg_rdata <= `RD_NONE;
        end
      endcase
    end else begin
      reg_rdata <= `RD_NONE;
    end
  end

endmodule // spi_error_power_irq
`default_nettype wire

/* File: spi_error_power_irq_props.sv */
// Port-level checker for the SPI core, bound into every instance.
// Assumes the select pin is the internal select (soft management off).
`default_nettype none
module spi_error_power_irq_props (
  input wire logic core_clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic cpu_irq_mask, // Mask
  input wire logic wait_mode, // Wait
  input wire logic halt_mode, // Halt
  input wire logic ss_n_in, // Select pin
  input wire logic sck_out, // Clock drive
  input wire logic sck_oe, // Clock enable
  input wire logic mosi_oe, // Master-out enable
  input wire logic miso_oe, // Master-in enable
  input wire logic spi_irq, // Request
  input wire logic wait_exit, // Wait end
  input wire logic halt_wake // Halt end
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ----
  // Mode fault steps
  // ----
  sequence fault_seen;
    sck_oe && !ss_n_in && !halt_mode;
  endsequence
  sequence outputs_off;
    !sck_oe && !mosi_oe;
  endsequence
  fault_drop_a: assert property (fault_seen |-> ##[1:3] outputs_off)
    else $error("master kept driving with select low");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  halt_read_a: assert property ($past(reg_rd) && $past(halt_mode) |-> reg_rdata == 8'h00)
    else $error("register answered during halt");
  irq_mask_a: assert property (cpu_irq_mask |=> !spi_irq)
    else $error("request raised while masked");
  wait_exit_a: assert property (wait_exit == (spi_irq && $past(wait_mode)))
    else $error("wait exit not tied to request");
  wake_pulse_a: assert property (halt_wake |=> !halt_wake)
    else $error("halt wake longer than one cycle");
  wake_gate_a: assert property (halt_wake |-> $past(halt_mode) && !$past(cpu_irq_mask))
    else $error("halt wake outside halt or masked");
  halt_freeze_a: assert property ($past(halt_mode, 2) && $past(halt_mode) && halt_mode |-> $stable(sck_out))
    else $error("serial clock moved in halt");
  role_oe_a: assert property (miso_oe |-> !sck_oe && !mosi_oe)
    else $error("slave and master drives together");
endmodule // spi_error_power_irq_props

bind spi_error_power_irq spi_error_power_irq_props props (.core_clk, .sys_rst, .reg_rd, .reg_rdata,
  .cpu_irq_mask, .wait_mode, .halt_mode, .ss_n_in, .sck_out, .sck_oe, .mosi_oe, .miso_oe,
  .spi_irq, .wait_exit, .halt_wake);
`default_nettype wire

/* File: spi_far_end.sv */
// Far end of the link: master for slave tests, answering slave otherwise.
// Assumes the bench resolves the shared lines and feeds them back.
`default_nettype none
module spi_far_end (
  input wire logic core_clk, // Clock
  input wire logic sck_w, // Clock line
  input wire logic mosi_w, // Master-out line
  input wire logic miso_w, // Master-in line
  output logic ss_n, // Select, pulled high
  output logic sck, // Clock drive
  output logic mosi, // Master-out drive
  output logic miso // Master-in drive
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv = 1'b0;
  logic sck_q = 1'b0;
  logic [7:0] sreg = 8'h00;
  logic [7:0] got = 8'h00;
  initial begin
    ss_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
  end
  assign miso = sreg[7];
  // Shift after the sampling edge, so the next bit never races it
  always @(posedge core_clk) begin
    sck_q <= sck_w;
    if (sck_w && !sck_q) begin
      got <= {got[6:0], drv ? miso_w : mosi_w};
      if (!drv)
        sreg <= {sreg[6:0], !sreg[0]};
    end
  end
  task automatic load(input logic [7:0] b);
    @(posedge core_clk);
    sreg <= b;
  endtask
  task automatic set_ss(input logic lvl);
    @(posedge core_clk);
    ss_n <= lvl;
  endtask
  task automatic send(input logic [7:0] b, input logic keep);
    repeat (4) @(posedge core_clk);
    drv <= 1'b1;
    ss_n <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi <= b[i];
      repeat (4) @(posedge core_clk);
      sck <= 1'b1;
      repeat (4) @(posedge core_clk);
      sck <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
    ss_n <= !keep;
    mosi <= !b[0];
    drv <= 1'b0;
  endtask
endmodule // spi_far_end
`default_nettype wire

/* File: test_spi_error_power_irq.sv */
// Self-checking bench for the SPI core against the far-end model.
// Assumes reads answer one cycle after the strobe.
`include "spi_map.vh"
`default_nettype none
module test_spi_error_power_irq;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic cpu_irq_mask = 1'b0;
  logic wait_mode = 1'b0;
  logic halt_mode = 1'b0;
  logic [7:0] reg_rdata;
  logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, spi_irq, wait_exit, halt_wake;
  logic ss_n_in, sck_in, mosi_in, miso_in, f_sck, f_mosi, f_miso;
  int n_mismatch = 0;
  int checked = 0;
  int n_wake = 0;
  always #2 core_clk = ~core_clk;
  assign sck_in = sck_oe ? sck_out : f_sck;
  assign mosi_in = mosi_oe ? mosi_out : f_mosi;
  assign miso_in = miso_oe ? miso_out : f_miso;
  always @(negedge core_clk) if (halt_wake === 1'b1) n_wake++;
  spi_error_power_irq dut (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cpu_irq_mask, .wait_mode, .halt_mode, .ss_n_in, .sck_in, .sck_out, .sck_oe, .mosi_in, .mosi_out,
    .mosi_oe, .miso_in, .miso_out, .miso_oe, .spi_irq, .wait_exit, .halt_wake);
  spi_far_end ext (.core_clk, .sck_w(sck_in), .mosi_w(mosi_in), .miso_w(miso_in), .ss_n(ss_n_in),
    .sck(f_sck), .mosi(f_mosi), .miso(f_miso));
  // ----
  // Bus and compare tasks
  // ----
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic rdc(input logic [1:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  task automatic wait_done(output logic [7:0] s);
    s = 8'h00;
    for (int i = 0; i < 100 && !s[7]; i++)
      rd(`ADDR_STAT, s);
  endtask
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    rdc(`ADDR_CTRL, `CR_RESET);
    rdc(`ADDR_STAT, 8'h00);
    rdc(2'h3, 8'h00);
    wr(`ADDR_STAT, 8'h07);
    rdc(`ADDR_STAT, 8'h07);
    wr(`ADDR_STAT, 8'h00);
    wr(`ADDR_CTRL, 8'h2f);
    rdc(`ADDR_CTRL, 8'h2f);
    $display("test reset done");
  endtask
  task automatic t_fault;
    wr(`ADDR_CTRL, 8'hd0);
    ext.set_ss(1'b0);
    idle(4);
    chk({7'h00, spi_irq}, 8'h01);
    @(posedge core_clk);
    cpu_irq_mask <= 1'b1;
    idle(2);
    chk({7'h00, spi_irq}, 8'h00);
    @(posedge core_clk);
    cpu_irq_mask <= 1'b0;
    rdc(`ADDR_CTRL, 8'h80);
    wr(`ADDR_CTRL, 8'hc0);
    rdc(`ADDR_CTRL, 8'h80);
    rdc(`ADDR_STAT, 8'h10);
    ext.set_ss(1'b1);
    wr(`ADDR_CTRL, 8'hd0);
    rdc(`ADDR_STAT, 8'h00);
    rdc(`ADDR_CTRL, 8'hd0);
    wr(`ADDR_CTRL, 8'h00);
    $display("test fault done");
  endtask
  task automatic t_master;
    logic [7:0] s;
    ext.load(8'h3c);
    wr(`ADDR_CTRL, 8'hf0);
    wr(`ADDR_DATA, 8'ha5);
    wr(`ADDR_DATA, 8'h11);
    idle(2);
    chk({7'h00, spi_irq}, 8'h00);
    wait_done(s);
    chk(s, 8'hc0);
    chk(ext.got, 8'ha5);
    ext.load(8'h3c);
    wr(`ADDR_DATA, 8'h77);
    rdc(`ADDR_STAT, 8'h40);
    wait_done(s);
    rdc(`ADDR_DATA, 8'h3c);
    rdc(`ADDR_STAT, 8'h00);
    chk(ext.got, 8'h77);
    wr(`ADDR_CTRL, 8'h00);
    $display("test master done");
  endtask
  // Idle-high clock, second-edge sampling, slower rate
  task automatic t_phase;
    logic [7:0] s;
    wr(`ADDR_CTRL, 8'hdc);
    idle(4);
    ext.load(8'h81);
    wr(`ADDR_DATA, 8'h5a);
    wait_done(s);
    chk(s, 8'h80);
    rdc(`ADDR_DATA, 8'h81);
    chk(ext.got, 8'h5a);
    wr(`ADDR_CTRL, 8'h00);
    $display("test phase done");
  endtask
  task automatic t_overrun;
    wr(`ADDR_CTRL, 8'hc0);
    wait_mode <= 1'b1;
    ext.send(8'hc3, 1'b0);
    ext.send(8'h96, 1'b0);
    idle(2);
    chk({7'h00, wait_exit}, 8'h01);
    chk(ext.got, 8'hc3);
    rdc(`ADDR_STAT, 8'ha0);
    rdc(`ADDR_DATA, 8'hc3);
    rdc(`ADDR_STAT, 8'h00);
    @(posedge core_clk);
    wait_mode <= 1'b0;
    $display("test overrun done");
  endtask
  // Halt entered with select low arms the wake, high leaves it idle
  task automatic t_halt(input logic arm, input logic [7:0] b);
    wr(`ADDR_CTRL, 8'hc0);
    ext.set_ss(!arm);
    idle(2);
    @(posedge core_clk);
    halt_mode <= 1'b1;
    rdc(`ADDR_STAT, 8'h00);
    n_wake = 0;
    ext.send(b, arm);
    idle(4);
    chk(n_wake[7:0], {7'h00, arm});
    @(posedge core_clk);
    halt_mode <= 1'b0;
    rdc(`ADDR_STAT, {arm, 7'h00});
    if (arm)
      rdc(`ADDR_DATA, b);
    $display("test halt done");
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset;
    t_fault;
    t_master;
    t_phase;
    t_overrun;
    t_halt(1'b0, 8'h69);
    t_halt(1'b1, 8'h5e);
    ext.send(8'h00, 1'b0);
    print_verdict;
  end
  initial begin
    idle(20000);
    n_mismatch++;
    print_verdict;
  end
endmodule // test_spi_error_power_irq
`default_nettype wire
